//--- bpwm_map.vh
`ifndef BPWM_MAP_VH
`define BPWM_MAP_VH

// Register byte offsets
`define BPWM_ADDR_W 8
`define BPWM_OFF_CH1_START 8'h00
`define BPWM_OFF_CH2_START 8'h04
`define BPWM_OFF_CH1_DUTY 8'h08
`define BPWM_OFF_CH2_DUTY 8'h0c
`define BPWM_OFF_MODE 8'h10
`define BPWM_OFF_BURST 8'h14
`define BPWM_OFF_STATUS 8'h18

// Start register fields: period byte and 10-bit duty
`define BPWM_PER_LSB 0
`define BPWM_PER_MSB 7
`define BPWM_DUTY_LSB 16
`define BPWM_DUTY_MSB 25
// Last timer count of a period is (period+1)*4-1, i.e. period with two ones below
`define BPWM_PER_TAIL 2'h3

// Mode register bits
`define BPWM_MODE_LP 0
`define BPWM_MODE_END 1
`define BPWM_MODE_HB 2
`define BPWM_MODE_W 3

// Burst register fields
`define BPWM_BDUTY_LSB 0
`define BPWM_BDUTY_MSB 7
`define BPWM_BCYC_LSB 8
`define BPWM_BCYC_MSB 15
`define BPWM_BURST_STEPS 256

// Status register fields
`define BPWM_ST_RUN_LSB 0
`define BPWM_ST_RUN_MSB 1
`define BPWM_ST_BACT 2
`define BPWM_ST_BREM_LSB 8
`define BPWM_ST_BREM_MSB 15
`define BPWM_ST_CNT_LSB 16
`define BPWM_ST_CNT_MSB 25

// Timing
`define BPWM_CLK_NS 5
`define BPWM_BURST_CYC_NS 5000000

// Bus answers and reset values
`define BPWM_RESP_OKAY 2'h0
`define BPWM_RESP_SLVERR 2'h2
`define BPWM_RST_PER 8'h00
`define BPWM_RST_DUTY 10'h000
`define BPWM_RST_MODE 3'h0

`endif

//--- bpwm_chan.v
`timescale 1ns/1ps
`include "bpwm_map.vh"

module bpwm_chan (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Shared timer and channel setup
  input wire [9:0] cnt,
  input wire [9:0] duty,
  input wire run,
  input wire hold,
  // Waveform
  output reg pwm_q
);

  // High from period start until the duty count, low for the rest
  always @(posedge aclk) begin
    if (!aresetn) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= run & ~hold & (cnt < duty);
    end
  end

endmodule // bpwm_chan

//--- bpwm_top.v
// Functional notes
// - Period lasts (period+1) times four clocks.
// - Mark lasts duty clocks, duty ten bits.
// - Waveform runs on until next start.
// - Start with period and duty zero stops.
// - Both channels share one period timer.
// - Output halts in low power, program end.
// - Start configures pin and resets timer.
// - Duty update never resets the timer.
// - Channel two blocked while half-bridge active.
// - Pins undriven until first start command.
// - Burst emits counted cycles, then releases pin.
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "bpwm_map.vh"

module bpwm_top #(
  parameter integer BURST_CYCLE_CLKS = `BPWM_BURST_CYC_NS / `BPWM_CLK_NS
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Continuous PWM pins
  output wire [1:0] pwm_o,
  output reg [1:0] pwm_oe_n,
  // Burst PWM pin
  output reg burst_o,
  output reg burst_oe_n
);

  localparam integer STEP_RAW = BURST_CYCLE_CLKS / `BPWM_BURST_STEPS;
  // A burst step never shrinks below one clock
  localparam integer STEP_CLKS = (STEP_RAW < 1) ? 1 : STEP_RAW;
  localparam [23:0] STEP_LAST = STEP_CLKS[23:0] - 24'h00_0001;

  // Bus holding registers
  reg [7:0] awaddr_q;
  reg aw_have_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_have_q;

  // Continuous PWM state
  reg [7:0] per_q;
  reg [19:0] duty_q;
  reg [1:0] run_q;
  reg [9:0] cnt_q;
  reg [2:0] mode_q;

  // Burst state
  reg bact_q;
  reg [7:0] bduty_q;
  reg [7:0] bcyc_q;
  reg [7:0] bphase_q;
  reg [23:0] bstep_q;

  wire wr_go;
  wire lp_hold;
  wire prog_end;
  wire hb_on;
  wire [9:0] cnt_last;
  wire [31:0] wmask;
  wire [31:0] wr_val;
  wire [7:0] nper;
  wire [9:0] nduty;
  wire start_off;
  wire step_end;
  wire bcyc_end;

  // A write commits once address and data are both held and no answer waits
  assign s_axi_awready = ~aw_have_q;
  assign s_axi_wready = ~w_have_q;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;

  assign lp_hold = mode_q[`BPWM_MODE_LP];
  assign prog_end = mode_q[`BPWM_MODE_END];
  assign hb_on = mode_q[`BPWM_MODE_HB];
  assign cnt_last = {per_q, `BPWM_PER_TAIL};

  // Register readback, shared by reads and by partial-strobe merges
  function [31:0] rd_word;
    input [7:0] a;
    begin
      rd_word = 32'h0000_0000;
      case (a)
        `BPWM_OFF_CH1_START: begin
          rd_word[`BPWM_PER_MSB:`BPWM_PER_LSB] = per_q;
          rd_word[`BPWM_DUTY_MSB:`BPWM_DUTY_LSB] = duty_q[9:0];
        end
        `BPWM_OFF_CH2_START: begin
          rd_word[`BPWM_PER_MSB:`BPWM_PER_LSB] = per_q;
          rd_word[`BPWM_DUTY_MSB:`BPWM_DUTY_LSB] = duty_q[19:10];
        end
        `BPWM_OFF_CH1_DUTY: begin
          rd_word[9:0] = duty_q[9:0];
        end
        `BPWM_OFF_CH2_DUTY: begin
          rd_word[9:0] = duty_q[19:10];
        end
        `BPWM_OFF_MODE: begin
          rd_word[`BPWM_MODE_W-1:0] = mode_q;
        end
        `BPWM_OFF_BURST: begin
          rd_word[`BPWM_BDUTY_MSB:`BPWM_BDUTY_LSB] = bduty_q;
          rd_word[`BPWM_BCYC_MSB:`BPWM_BCYC_LSB] = bcyc_q;
        end
        `BPWM_OFF_STATUS: begin
          rd_word[`BPWM_ST_RUN_MSB:`BPWM_ST_RUN_LSB] = run_q;
          rd_word[`BPWM_ST_BACT] = bact_q;
          rd_word[`BPWM_ST_BREM_MSB:`BPWM_ST_BREM_LSB] = bcyc_q;
          rd_word[`BPWM_ST_CNT_MSB:`BPWM_ST_CNT_LSB] = cnt_q;
        end
        default: begin
          rd_word = 32'h0000_0000;
        end
      endcase
    end
  endfunction

  // Decode of the mapped word addresses
  function mapped;
    input [7:0] a;
    begin
      case (a)
        `BPWM_OFF_CH1_START,
        `BPWM_OFF_CH2_START,
        `BPWM_OFF_CH1_DUTY,
        `BPWM_OFF_CH2_DUTY,
        `BPWM_OFF_MODE,
        `BPWM_OFF_BURST,
        `BPWM_OFF_STATUS: begin
          mapped = 1'b1;
        end
        default: begin
          mapped = 1'b0;
        end
      endcase
    end
  endfunction

  // Byte strobes expand to a bit mask, one lane per loop pass
  genvar gl;
  generate
    for (gl = 0; gl < 4; gl = gl + 1) begin : g_lane
      assign wmask[gl*8 +: 8] = {8{wstrb_q[gl]}};
    end
  endgenerate

  // Unstrobed lanes keep their current value, so a command sees whole fields
  assign wr_val = (rd_word(awaddr_q) & ~wmask) | (wdata_q & wmask);
  assign nper = wr_val[`BPWM_PER_MSB:`BPWM_PER_LSB];
  assign nduty = wr_val[`BPWM_DUTY_MSB:`BPWM_DUTY_LSB];
  assign start_off = (nper == `BPWM_RST_PER) && (nduty == `BPWM_RST_DUTY);

  // Write address and data channels are taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= 8'h00;
      aw_have_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      w_have_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_have_q) begin
        awaddr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_have_q) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end else if (wr_go) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR and change nothing
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BPWM_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(awaddr_q) ? `BPWM_RESP_OKAY : `BPWM_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: one cycle from address to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `BPWM_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word(s_axi_araddr);
      s_axi_rresp <= mapped(s_axi_araddr) ? `BPWM_RESP_OKAY : `BPWM_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Commands and the shared period timer. Starts reset the timer; duty
  // updates do not, so a running waveform changes without a glitch.
  always @(posedge aclk) begin
    if (!aresetn) begin
      per_q <= `BPWM_RST_PER;
      duty_q <= {`BPWM_RST_DUTY, `BPWM_RST_DUTY};
      run_q <= 2'b00;
      cnt_q <= 10'h000;
      mode_q <= `BPWM_RST_MODE;
      pwm_oe_n <= 2'b11;
    end else begin
      // Free-running timer wraps at the period end
      if (lp_hold) begin
        cnt_q <= cnt_q;
      end else if (run_q != 2'b00) begin
        cnt_q <= (cnt_q == cnt_last) ? 10'h000 : cnt_q + 10'h001;
      end else begin
        cnt_q <= 10'h000;
      end
      if (wr_go) begin
        case (awaddr_q)
          `BPWM_OFF_CH1_START: begin
            if (start_off) begin
              run_q[0] <= 1'b0;
            end else begin
              per_q <= nper;
              duty_q[9:0] <= nduty;
              run_q[0] <= 1'b1;
              pwm_oe_n[0] <= 1'b0;
              cnt_q <= 10'h000;
            end
          end
          `BPWM_OFF_CH2_START: begin
            if (start_off) begin
              run_q[1] <= 1'b0;
            end else if (!hb_on) begin
              per_q <= nper;
              duty_q[19:10] <= nduty;
              run_q[1] <= 1'b1;
              pwm_oe_n[1] <= 1'b0;
              cnt_q <= 10'h000;
            end
          end
          `BPWM_OFF_CH1_DUTY: begin
            if (run_q[0]) begin
              duty_q[9:0] <= wr_val[9:0];
            end
          end
          `BPWM_OFF_CH2_DUTY: begin
            if (run_q[1]) begin
              duty_q[19:10] <= wr_val[9:0];
            end
          end
          `BPWM_OFF_MODE: begin
            mode_q <= wr_val[`BPWM_MODE_W-1:0];
          end
          default: begin
            per_q <= per_q;
          end
        endcase
      end
      // Program end stops both channels; half-bridge takes channel two
      if (prog_end) begin
        run_q <= 2'b00;
      end else if (hb_on) begin
        run_q[1] <= 1'b0;
      end
    end
  end

  // One compare per channel on the shared timer
  genvar gc;
  generate
    for (gc = 0; gc < 2; gc = gc + 1) begin : g_chan
      bpwm_chan u_chan (
        .aclk(aclk),
        .aresetn(aresetn),
        .cnt(cnt_q),
        .duty(duty_q[gc*10 +: 10]),
        .run(run_q[gc]),
        .hold(lp_hold | prog_end | (hb_on & (gc == 1))),
        .pwm_q(pwm_o[gc])
      );
    end
  endgenerate

  // Burst step divider: each burst cycle is split into 256 duty steps
  assign step_end = (bstep_q == STEP_LAST);
  assign bcyc_end = step_end && (bphase_q == 8'hff);

  // Burst engine. It runs a fixed count of cycles and then lets go of the
  // pin; a new burst write restarts it from the first step.
  always @(posedge aclk) begin
    if (!aresetn) begin
      bact_q <= 1'b0;
      bduty_q <= 8'h00;
      bcyc_q <= 8'h00;
      bphase_q <= 8'h00;
      bstep_q <= 24'h00_0000;
    end else if (wr_go && (awaddr_q == `BPWM_OFF_BURST)) begin
      bduty_q <= wr_val[`BPWM_BDUTY_MSB:`BPWM_BDUTY_LSB];
      bcyc_q <= wr_val[`BPWM_BCYC_MSB:`BPWM_BCYC_LSB];
      bact_q <= (wr_val[`BPWM_BCYC_MSB:`BPWM_BCYC_LSB] != 8'h00);
      bphase_q <= 8'h00;
      bstep_q <= 24'h00_0000;
    end else if (prog_end) begin
      bact_q <= 1'b0;
      bcyc_q <= 8'h00;
    end else if (bact_q && !lp_hold) begin
      bstep_q <= step_end ? 24'h00_0000 : bstep_q + 24'h00_0001;
      if (step_end) begin
        bphase_q <= bphase_q + 8'h01;
      end
      if (bcyc_end) begin
        bcyc_q <= bcyc_q - 8'h01;
        bact_q <= (bcyc_q != 8'h01);
      end
    end
  end

  // Burst pin is driven only while a burst runs, then floats as an input
  always @(posedge aclk) begin
    if (!aresetn) begin
      burst_o <= 1'b0;
      burst_oe_n <= 1'b1;
    end else begin
      burst_o <= bact_q && !lp_hold && !prog_end && (bphase_q < bduty_q);
      burst_oe_n <= ~bact_q;
    end
  end

endmodule // bpwm_top

//--- bpwm_properties.sv
`timescale 1ns/1ps
`include "bpwm_map.vh"

module bpwm_props #(
  parameter integer BURST_CYCLE_CLKS = 512
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Write channels
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  // Pins
  input wire [1:0] pwm_o,
  input wire [1:0] pwm_oe_n,
  input wire burst_o,
  input wire burst_oe_n
);
  reg [7:0] a_q;
  reg [31:0] d_q;
  reg [7:0] per_q;
  reg [7:0] nb_q;
  reg [2:0] mode_q;
  reg bv_q;
  reg [1:0] armed_q;
  reg [11:0] gap_q;
  reg [19:0] bl_q;
  wire ev = s_axi_bvalid & ~bv_q;
  wire st = ev && a_q <= `BPWM_OFF_CH2_START;

  // Shadow trails the commit by a cycle, so checks never race it
  always @(posedge aclk) begin
    if (!aresetn) begin
      bv_q <= 1'b0;
      armed_q <= 2'b00;
      mode_q <= 3'h0;
      per_q <= 8'h00;
      nb_q <= 8'h00;
      gap_q <= 12'h000;
      bl_q <= 20'h00000;
    end else begin
      bv_q <= s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready) a_q <= s_axi_awaddr;
      if (s_axi_wvalid & s_axi_wready) d_q <= s_axi_wdata;
      gap_q <= $rose(pwm_o[0]) ? 12'h001 : gap_q + 12'h001;
      bl_q <= burst_oe_n ? 20'h00000 : bl_q + 20'h00001;
      if (ev && a_q == `BPWM_OFF_MODE) mode_q <= d_q[2:0];
      if (ev && a_q == `BPWM_OFF_BURST) nb_q <= d_q[15:8];
      if (st) per_q <= d_q[7:0];
      // Duty updates keep the arming, so a timer restart on them is caught;
      // a resumed timer may give a short first period, so arm on the second rise
      if (st || (ev && a_q == `BPWM_OFF_MODE)) armed_q <= 2'b00;
      else if ($rose(pwm_o[0]) && !armed_q[1]) armed_q <= armed_q + 2'b01;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_period_len: assert property (
    $rose(pwm_o[0]) && armed_q[1] |-> gap_q == {2'b00, per_q, 2'b11} + 12'h001)
    else $error("period length wrong");
  a_start_marks: assert property (
    st && a_q == `BPWM_OFF_CH1_START && d_q[25:16] == 10'h003 && d_q[7:0] != 8'h00
    && mode_q == 3'h0 |=> (pwm_o[0] && !pwm_oe_n[0]) [*3] ##1 !pwm_o[0])
    else $error("mark after start wrong");
  a_off_quiet: assert property (
    st && a_q == `BPWM_OFF_CH1_START && d_q[25:0] == 26'h0 |=> !pwm_o[0] [*8])
    else $error("output runs after off");
  a_low_power: assert property (
    mode_q[1:0] != 2'b00 |-> pwm_o == 2'b00 && !burst_o)
    else $error("output runs while halted");
  a_half_bridge: assert property (
    mode_q[2] |-> !pwm_o[1])
    else $error("channel two runs beside half bridge");
  a_oe_sticks: assert property (
    pwm_oe_n != 2'b11 |=> (pwm_oe_n & ~$past(pwm_oe_n)) == 2'b00)
    else $error("started pin released");
  a_undriven_low: assert property (
    pwm_oe_n[1] |-> !pwm_o[1])
    else $error("unstarted channel marks");
  a_shared_timer: assert property (
    $rose(pwm_o[1]) && armed_q[1] && mode_q == 3'h0 |-> $rose(pwm_o[0]))
    else $error("channel periods apart");
  a_burst_release: assert property (
    $rose(burst_oe_n) |-> bl_q + 20'h00002 >= nb_q * BURST_CYCLE_CLKS
    && bl_q <= nb_q * BURST_CYCLE_CLKS + 2 ##1 !burst_o)
    else $error("burst length wrong");
endmodule // bpwm_props

bind bpwm_top bpwm_props #(.BURST_CYCLE_CLKS(BURST_CYCLE_CLKS)) bpwm_props_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .pwm_o(pwm_o), .pwm_oe_n(pwm_oe_n), .burst_o(burst_o), .burst_oe_n(burst_oe_n));

//--- bpwm_load.sv
`timescale 1ns/1ps

module bpwm_load (
  // Driver side
  input wire [1:0] pwm_o,
  input wire [1:0] pwm_oe_n,
  input wire burst_o,
  input wire burst_oe_n,
  // Level at the load
  output wire [2:0] pin_lvl
);
  // Pull-down keeps the FET off whenever a pin floats
  assign pin_lvl = {~burst_oe_n & burst_o, ~pwm_oe_n & pwm_o};
endmodule // bpwm_load

//--- tb_background_pwm_generator.sv
`timescale 1ns/1ps
`include "bpwm_map.vh"

module tb_background_pwm_generator;
  localparam integer BC = 512;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] awaddr = 8'h00;
  reg [7:0] araddr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0;
  reg wvalid = 1'b0;
  reg bready = 1'b0;
  reg arvalid = 1'b0;
  reg rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, burst_o, burst_oe_n;
  wire [1:0] bresp, rresp, pwm_o, pwm_oe_n;
  wire [31:0] rdata;
  wire [2:0] pin_lvl;
  integer fails = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  integer bl = 0;
  integer bh = 0;
  integer i, n;
  reg [10:0] hi, pd;
  reg [39:0] rows [0:3];

  always #2.5 aclk = ~aclk;

  bpwm_top #(.BURST_CYCLE_CLKS(BC)) bpwm_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pwm_o(pwm_o), .pwm_oe_n(pwm_oe_n),
    .burst_o(burst_o), .burst_oe_n(burst_oe_n));
  bpwm_load bpwm_load_i (.pwm_o(pwm_o), .pwm_oe_n(pwm_oe_n), .burst_o(burst_o),
    .burst_oe_n(burst_oe_n), .pin_lvl(pin_lvl));

  task chk(input [95:0] what, input [31:0] exp, input [31:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("unexpected %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask

  // A hang ends the run as a mismatch
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails = fails + 1;
      test_done;
    end
  end

  // Burst counted apart, so its first cycles are never missed
  always @(negedge aclk) begin
    if (burst_oe_n === 1'b0) begin
      bl = bl + 1;
      bh = bh + pin_lvl[2];
    end
  end

  // Ready sampled mid-cycle, released just after the taking edge
  task wr(input [7:0] a, input [31:0] d, input [1:0] rsp);
    reg ha, hw, done;
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(negedge aclk);
        ha = awready;
        hw = wready;
        done = bvalid;
        if (done) chk("bresp", 32'(rsp), 32'(bresp));
        @(posedge aclk);
        if (ha) awvalid <= 1'b0;
        if (hw) wvalid <= 1'b0;
        if (done) bready <= 1'b0;
      end
    end
  endtask

  task rd(input [7:0] a, input [31:0] exp, input [1:0] rsp);
    reg ha, done;
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(negedge aclk);
        ha = arready;
        done = rvalid;
        if (done) chk("rdata", exp, rdata);
        if (done) chk("rresp", 32'(rsp), 32'(rresp));
        @(posedge aclk);
        if (ha) arvalid <= 1'b0;
        if (done) rready <= 1'b0;
      end
    end
  endtask

  // One full period from a rising edge of the pin
  task meas(input integer w);
    begin
      hi = 11'h0;
      pd = 11'h0;
      n = 0;
      // Skip a partial mark left by a restart or a resumed timer
      while (pin_lvl[w] !== 1'b1 && n < 3000) begin
        @(negedge aclk);
        n = n + 1;
      end
      while (pin_lvl[w] !== 1'b0 && n < 3000) begin
        @(negedge aclk);
        n = n + 1;
      end
      while (pin_lvl[w] !== 1'b1 && n < 3000) begin
        @(negedge aclk);
        n = n + 1;
      end
      while (pin_lvl[w] === 1'b1 && n < 3000) begin
        @(negedge aclk);
        hi = hi + 11'h1;
        n = n + 1;
      end
      while (pin_lvl[w] === 1'b0 && n < 3000) begin
        @(negedge aclk);
        pd = pd + 11'h1;
        n = n + 1;
      end
      pd = pd + hi;
      chk("meas time", 32'h0, 32'(n >= 3000));
    end
  endtask

  task quiet(input integer w);
    reg seen;
    begin
      seen = 1'b0;
      repeat (40) begin
        @(negedge aclk);
        seen = seen | pin_lvl[w];
      end
      chk("quiet pin", 32'h0, 32'(seen));
    end
  endtask

  initial begin
    // Period, duty, mark and period clocks; duty within (period+1) times four
    // No servo use and no clock switch while PWM runs
    rows[0] = {8'h01, 10'h003, 11'h003, 11'h008};
    rows[1] = {8'h00, 10'h002, 11'h002, 11'h004};
    rows[2] = {8'h04, 10'h010, 11'h010, 11'h014};
    rows[3] = {8'hff, 10'h3fc, 11'h3fc, 11'h400};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("oe_n", 32'h3, 32'(pwm_oe_n));
    rd(`BPWM_OFF_MODE, 32'h0, `BPWM_RESP_OKAY);
    rd(8'h40, 32'h0, `BPWM_RESP_SLVERR);
    wr(8'h40, 32'hffff_ffff, `BPWM_RESP_SLVERR);
    wr(`BPWM_OFF_CH2_DUTY, 32'h5, `BPWM_RESP_OKAY);
    quiet(1);
    $display("test reset and bus done");
    for (i = 0; i < 4; i = i + 1) begin
      wr(`BPWM_OFF_CH1_START, {6'h0, rows[i][31:22], 8'h0, rows[i][39:32]},
        `BPWM_RESP_OKAY);
      meas(0);
      chk("mark", 32'(rows[i][21:11]), 32'(hi));
      chk("period", 32'(rows[i][10:0]), 32'(pd));
    end
    $display("test table done");
    wr(`BPWM_OFF_CH1_START, 32'h0010_0004, `BPWM_RESP_OKAY);
    wr(`BPWM_OFF_CH1_DUTY, 32'h4, `BPWM_RESP_OKAY);
    meas(0);
    chk("mark", 32'h4, 32'(hi));
    chk("period", 32'h14, 32'(pd));
    wr(`BPWM_OFF_CH2_START, 32'h0008_0004, `BPWM_RESP_OKAY);
    meas(1);
    chk("period2", 32'h14, 32'(pd));
    rd(`BPWM_OFF_CH1_START, 32'h0004_0004, `BPWM_RESP_OKAY);
    $display("test duty update and shared timer done");
    wr(`BPWM_OFF_MODE, 32'h4, `BPWM_RESP_OKAY);
    quiet(1);
    wr(`BPWM_OFF_CH2_START, 32'h0008_0004, `BPWM_RESP_OKAY);
    quiet(1);
    meas(0);
    chk("mark", 32'h4, 32'(hi));
    wr(`BPWM_OFF_MODE, 32'h1, `BPWM_RESP_OKAY);
    quiet(0);
    wr(`BPWM_OFF_MODE, 32'h0, `BPWM_RESP_OKAY);
    meas(0);
    chk("period", 32'h14, 32'(pd));
    wr(`BPWM_OFF_CH1_START, 32'h0, `BPWM_RESP_OKAY);
    quiet(0);
    chk("oe_n0", 32'h0, 32'(pwm_oe_n[0]));
    wr(`BPWM_OFF_CH1_START, 32'h0010_0004, `BPWM_RESP_OKAY);
    wr(`BPWM_OFF_MODE, 32'h2, `BPWM_RESP_OKAY);
    wr(`BPWM_OFF_MODE, 32'h0, `BPWM_RESP_OKAY);
    quiet(0);
    $display("test modes and off done");
    wr(`BPWM_OFF_BURST, 32'h0, `BPWM_RESP_OKAY);
    wr(`BPWM_OFF_BURST, 32'h0000_0280, `BPWM_RESP_OKAY);
    n = 0;
    // Enable is registered: look only once the start edge has settled
    @(negedge aclk);
    while (burst_oe_n !== 1'b1 && n < 3000) begin
      @(negedge aclk);
      n = n + 1;
    end
    chk("burst len", 2 * BC, bl);
    chk("burst mark", BC, bh);
    $display("test burst done");
    // Reset in mid-run must release the pins again
    wr(`BPWM_OFF_CH1_START, 32'h0010_0004, `BPWM_RESP_OKAY);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("oe_n", 32'h3, 32'(pwm_oe_n));
    $display("test mid-run reset done");
    test_done;
  end
endmodule // tb_background_pwm_generator
